// file: pfms_params.svh
// Purpose: Named constants for the pin-function and mode-select block.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef PFMS_PARAMS_SVH
`define PFMS_PARAMS_SVH
`define PFMS_ADDR_W 4
`define PFMS_ADDR_CTRL 4'h0
`define PFMS_ADDR_FLAG_DIR 4'h1
`define PFMS_ADDR_FLAG_OUT 4'h2
`define PFMS_ADDR_FLAG_IN 4'h3
`define PFMS_ADDR_STATUS 4'h4
`define PFMS_ADDR_PENDING 4'h5
`define PFMS_ADDR_HOST_OUT 4'h6
`define PFMS_ADDR_EXT 4'h7
`define PFMS_ADDR_HOST_IN 4'h8
`define PFMS_CTRL_SERIAL_ALT 0
`define PFMS_CTRL_EDGE_SEL 1
`define PFMS_CTRL_ALT_FLAG_OUT 2
`define PFMS_CTRL_SCLK_EN 3
`define PFMS_CTRL_BUS_GRANT_EN 4
`define PFMS_CTRL_MEM_RD 5
`define PFMS_CTRL_MEM_WR 6
`define PFMS_CTRL_ACK 7
`define PFMS_CTRL_FIXED_LSB 8
`define PFMS_CTRL_FIXED_MSB 10
`define PFMS_CTRL_SEL_LSB 11
`define PFMS_CTRL_SEL_MSB 15
`define PFMS_CTRL_PWD_ACK 16
`define PFMS_CTRL_W 17
`define PFMS_STRAP_HOST 2
`define PFMS_STRAP_ACK_CFG 3
`define PFMS_NUM_FLAGS 8
`define PFMS_NUM_IRQ 6
`define PFMS_EXT_ADDR_W 14
`define PFMS_EXT_DATA_W 24
`define PFMS_BYTE_ADDR_W 8
`define PFMS_HOST_W 16
`define PFMS_DATA_W 32
`define PFMS_ZERO32 32'h0000_0000
`define PFMS_HUNG_LIMIT 8'hFF
`endif

// file: pfms_pkg.sv
// Purpose: Types for the pin-function and mode-select block.
// Assumes: Nothing.
// Notes: Constants live in pfms_params.svh.
package pfms_pkg;
	typedef enum logic [0:0] {
		PFMS_MODE_FULL_MEM = 1'b0,
		PFMS_MODE_HOST = 1'b1
	} pfms_mode_e;
	typedef enum logic [1:0] {
		PFMS_BUS_OWN = 2'b00,
		PFMS_BUS_GRANTED = 2'b01,
		PFMS_BUS_HUNG = 2'b10
	} pfms_bus_e;
endpackage : pfms_pkg

// file: pfms_sync2.sv
// Purpose: Two-stage synchroniser for a bundle of pin levels.
// Assumes: Inputs arrive from outside the clock domain.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module pfms_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : pfms_sync2
`default_nettype wire

// file: pfms_irq_detect.sv
// Purpose: Level and edge detection for the shared interrupt/flag pins.
// Assumes: Pin levels already synchronised; pins are active low.
// Notes: Pending edges are held until cleared; a new edge wins over a clear.
`timescale 1ns/1ps
`default_nettype none
module pfms_irq_detect (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Pin levels, active low
	input wire logic [5:0] pin_n_in,
	// Configuration
	input wire logic [5:0] edge_mode_in,
	input wire logic [5:0] clear_in,
	// Requests
	output logic [5:0] request_out
);
	logic [5:0] prev_reg;
	logic [5:0] pend_reg;
	logic [5:0] fall;
	assign fall = prev_reg & ~pin_n_in;
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_reg <= 6'h00;
		end else begin
			prev_reg <= pin_n_in;
		end
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_reg <= 6'h00;
		end else begin
			pend_reg <= (pend_reg & ~clear_in) | fall;
		end
	end
	always_comb begin
		request_out = (edge_mode_in & pend_reg) | (~edge_mode_in & ~pin_n_in);
	end
endmodule : pfms_irq_detect
`default_nettype wire

// file: pfms_pin_select.sv
// Purpose: Pin-function and operating-mode selection for the processor pins.
// Assumes: One clock, asynchronous active-low reset, plain register port.
// Notes: Straps are caught at reset release; bus pins fixed until next reset.
//
// Summary of operation
// - External bus pin functions are fixed at reset and never change while running.
// - Software may switch serial port b pins between primary and alternate at any time.
// - Shared flag/interrupt pins keep both functions active at once.
// - The four mode straps count as mode information only during reset.
// - After reset the strap pins are programmable flags zero through three.
// - Host strap low gives full memory mode, high gives host mode.
// - Full memory mode drives 14 address bits and 24 data bits.
// - Host mode gives a 16-bit host port, one address bit, upper 16 data bits.
// - Host acknowledge is open drain, its behaviour set by the fourth strap.
// - An enabled shared pin raises its interrupt whoever asserts it.
// - One pin edge or level, two level, one edge interrupts; all flags.
// - Separate active-low selects, a combined select, read and write enables.
// - Bus request is answered by bus grant; a grant-hung output exists.
// - Power-down request input and power-down acknowledge output.
// - Internal serial clock stays usable in the alternate configuration.
`timescale 1ns/1ps
`default_nettype none
`include "pfms_params.svh"
module pfms_pin_select (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Interrupt mask and vector requests
	input wire logic [5:0] interrupt_mask_in,
	output logic [5:0] irq_vector_req_out,
	// Programmable flag pins, index 0 to 7
	input wire logic [7:0] prog_flag_in,
	output logic [7:0] prog_flag_out,
	output logic [7:0] prog_flag_oe_out,
	// Fixed output flags
	output logic [2:0] fixed_output_flags_out,
	// Serial port b shared pins
	input wire logic serial_b_rx_in,
	input wire logic serial_b_rfs_in,
	input wire logic serial_b_tfs_in,
	input wire logic serial_b_tx_data_in,
	input wire logic serial_b_sclk_int_in,
	output logic serial_b_rx_data_out,
	output logic serial_b_tx_out,
	output logic serial_b_sclk_out,
	// External memory bus
	output logic [13:0] ext_addr_out,
	input wire logic [23:0] ext_data_io_in,
	output logic [23:0] ext_data_io_out,
	output logic [23:0] ext_data_io_oe_out,
	// Host port
	input wire logic host_write_n_in,
	input wire logic host_read_n_in,
	input wire logic host_addr_latch_in,
	input wire logic host_select_n_in,
	output logic host_ack_n_out,
	output logic host_ack_n_oe_out,
	// Memory selects and strobes
	output logic data_mem_sel_n_out,
	output logic prog_mem_sel_n_out,
	output logic io_space_sel_n_out,
	output logic byte_mem_sel_n_out,
	output logic combined_sel_n_out,
	output logic mem_read_n_out,
	output logic mem_write_n_out,
	// Bus arbitration
	input wire logic bus_req_n_in,
	output logic bus_grant_n_out,
	output logic bus_grant_hung_n_out,
	// Power down
	input wire logic powerdown_req_n_in,
	output logic powerdown_ack_out,
	// Captured mode
	output logic host_mode_out
);
	logic [7:0] flag_s;
	logic [23:0] data_s;
	logic [5:0] ctl_s;
	logic [4:0] ser_s;
	logic [3:0] strap_reg;
	logic strap_take_reg;
	logic [16:0] ctrl_reg;
	logic [7:0] flag_dir_reg;
	logic [7:0] flag_val_reg;
	logic [15:0] host_out_reg;
	logic [23:0] ext_reg;
	logic [5:0] clr_pulse;
	logic [5:0] req;
	logic [5:0] irq_pin_n;
	logic [5:0] edge_mode;
	pfms_pkg::pfms_bus_e bus_st_reg;
	logic [7:0] hung_cnt_reg;
	logic [31:0] rdata_next;
	logic host_mode;
	logic serial_alt;
	// Input synchronisers for all pins.
	pfms_sync2 #(.WIDTH(8)) u_sync_flag (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.async_in(prog_flag_in), .sync_out(flag_s));
	pfms_sync2 #(.WIDTH(24)) u_sync_data (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.async_in(ext_data_io_in), .sync_out(data_s));
	pfms_sync2 #(.WIDTH(6)) u_sync_ctl (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.async_in({host_write_n_in, host_read_n_in, host_addr_latch_in, host_select_n_in,
			bus_req_n_in, powerdown_req_n_in}), .sync_out(ctl_s));
	pfms_sync2 #(.WIDTH(5)) u_sync_ser (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.async_in({serial_b_rx_in, serial_b_rfs_in, serial_b_tfs_in, 2'b11}),
		.sync_out(ser_s));
	// Straps sampled on every edge during reset and last on the first edge after reset release.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_take_reg <= 1'b1;
		end else begin
			strap_take_reg <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (strap_take_reg) begin
			strap_reg <= prog_flag_in[3:0];
		end
	end
	assign host_mode = strap_reg[`PFMS_STRAP_HOST] == 1'(pfms_pkg::PFMS_MODE_HOST);
	assign serial_alt = ctrl_reg[`PFMS_CTRL_SERIAL_ALT];
	// Register writes.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= 17'h1F800;
			flag_dir_reg <= 8'h00;
			flag_val_reg <= 8'h00;
			host_out_reg <= 16'h0000;
			ext_reg <= 24'h000000;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `PFMS_ADDR_CTRL) begin
				ctrl_reg <= reg_wdata_in[16:0];
			end else if (reg_addr_in == `PFMS_ADDR_FLAG_DIR) begin
				flag_dir_reg <= reg_wdata_in[7:0];
			end else if (reg_addr_in == `PFMS_ADDR_FLAG_OUT) begin
				flag_val_reg <= reg_wdata_in[7:0];
			end else if (reg_addr_in == `PFMS_ADDR_HOST_OUT) begin
				host_out_reg <= reg_wdata_in[15:0];
			end else if (reg_addr_in == `PFMS_ADDR_EXT) begin
				ext_reg <= reg_wdata_in[23:0];
			end
		end
	end
	always_comb begin
		clr_pulse = 6'h00;
		if (reg_wr_in && reg_addr_in == `PFMS_ADDR_PENDING) begin
			clr_pulse = reg_wdata_in[5:0];
		end
	end
	// Interrupt pins: 7 edge/level, 6 and 5 level, 4 edge, then alt irqs b and a.
	assign irq_pin_n = {flag_s[7:4], ser_s[4], ser_s[3]};
	assign edge_mode = {ctrl_reg[`PFMS_CTRL_EDGE_SEL], 2'b00, 1'b1, 1'b1, 1'b1};
	pfms_irq_detect u_irq (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.pin_n_in(irq_pin_n), .edge_mode_in(edge_mode), .clear_in(clr_pulse),
		.request_out(req));
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_vector_req_out <= 6'h00;
		end else begin
			irq_vector_req_out <= req & interrupt_mask_in & {4'hF, {2{serial_alt}}};
		end
	end
	// Flag pins: drive when direction bit set; flags keep their interrupt meaning.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prog_flag_out <= 8'h00;
			prog_flag_oe_out <= 8'h00;
			fixed_output_flags_out <= 3'h0;
		end else begin
			prog_flag_out <= flag_val_reg;
			prog_flag_oe_out <= strap_take_reg ? 8'h00 : flag_dir_reg;
			fixed_output_flags_out <= ctrl_reg[`PFMS_CTRL_FIXED_MSB:`PFMS_CTRL_FIXED_LSB];
		end
	end
	// Serial port b pin sharing.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			serial_b_rx_data_out <= 1'b0;
			serial_b_tx_out <= 1'b0;
			serial_b_sclk_out <= 1'b0;
		end else begin
			serial_b_rx_data_out <= serial_alt ? 1'b0 : ser_s[4];
			serial_b_tx_out <= serial_alt ? ctrl_reg[`PFMS_CTRL_ALT_FLAG_OUT]
				: serial_b_tx_data_in;
			serial_b_sclk_out <= ctrl_reg[`PFMS_CTRL_SCLK_EN] & serial_b_sclk_int_in;
		end
	end
	// Bus arbitration with hung indication.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_st_reg <= pfms_pkg::PFMS_BUS_OWN;
			hung_cnt_reg <= 8'h00;
		end else begin
			case (bus_st_reg)
				pfms_pkg::PFMS_BUS_OWN: begin
					if (!ctl_s[1]) begin
						bus_st_reg <= ctrl_reg[`PFMS_CTRL_BUS_GRANT_EN] ? pfms_pkg::PFMS_BUS_GRANTED
							: pfms_pkg::PFMS_BUS_HUNG;
					end
				end
				pfms_pkg::PFMS_BUS_GRANTED: begin
					if (ctl_s[1]) begin
						bus_st_reg <= pfms_pkg::PFMS_BUS_OWN;
					end
				end
				default: begin
					if (hung_cnt_reg != `PFMS_HUNG_LIMIT) begin
						hung_cnt_reg <= hung_cnt_reg + 8'h01;
					end
					if (ctl_s[1] || ctrl_reg[`PFMS_CTRL_BUS_GRANT_EN]) begin
						bus_st_reg <= ctl_s[1] ? pfms_pkg::PFMS_BUS_OWN : pfms_pkg::PFMS_BUS_GRANTED;
						hung_cnt_reg <= 8'h00;
					end
				end
			endcase
		end
	end
	// Pin drive by mode.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_addr_out <= 14'h0000;
			ext_data_io_out <= 24'h000000;
			ext_data_io_oe_out <= 24'h000000;
			host_ack_n_out <= 1'b0;
			host_ack_n_oe_out <= 1'b0;
		end else if (host_mode) begin
			ext_addr_out <= {host_out_reg[12:0], ext_reg[0]};
			ext_data_io_out <= {ext_reg[23:8], host_out_reg[7:0]};
			ext_data_io_oe_out <= {{16{ctrl_reg[`PFMS_CTRL_MEM_WR]}},
				{8{!ctl_s[4] && !ctl_s[2]}}};
			host_ack_n_out <= 1'b0;
			host_ack_n_oe_out <= strap_reg[`PFMS_STRAP_ACK_CFG] ? ctrl_reg[`PFMS_CTRL_ACK]
				: !ctl_s[2] && ctrl_reg[`PFMS_CTRL_ACK];
		end else begin
			ext_addr_out <= ext_reg[13:0];
			ext_data_io_out <= {host_out_reg[7:0], ext_reg[15:0]};
			ext_data_io_oe_out <= {24{ctrl_reg[`PFMS_CTRL_MEM_WR]
				&& bus_st_reg == pfms_pkg::PFMS_BUS_OWN}};
			host_ack_n_out <= 1'b0;
			host_ack_n_oe_out <= 1'b0;
		end
	end
	// Selects, strobes, grant and power down.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{combined_sel_n_out, byte_mem_sel_n_out, io_space_sel_n_out} <= 3'h7;
			{prog_mem_sel_n_out, data_mem_sel_n_out} <= 2'h3;
			mem_read_n_out <= 1'b1;
			mem_write_n_out <= 1'b1;
			bus_grant_n_out <= 1'b1;
			bus_grant_hung_n_out <= 1'b1;
			powerdown_ack_out <= 1'b0;
			host_mode_out <= 1'b0;
		end else begin
			{combined_sel_n_out, byte_mem_sel_n_out, io_space_sel_n_out, prog_mem_sel_n_out,
				data_mem_sel_n_out} <= ctrl_reg[`PFMS_CTRL_SEL_MSB:`PFMS_CTRL_SEL_LSB];
			mem_read_n_out <= !ctrl_reg[`PFMS_CTRL_MEM_RD];
			mem_write_n_out <= !ctrl_reg[`PFMS_CTRL_MEM_WR];
			bus_grant_n_out <= bus_st_reg != pfms_pkg::PFMS_BUS_GRANTED;
			bus_grant_hung_n_out <= !(bus_st_reg == pfms_pkg::PFMS_BUS_HUNG
				&& hung_cnt_reg == `PFMS_HUNG_LIMIT);
			powerdown_ack_out <= !ctl_s[0] && ctrl_reg[`PFMS_CTRL_PWD_ACK];
			host_mode_out <= host_mode && !strap_take_reg;
		end
	end
	// Register reads.
	always_comb begin
		rdata_next = `PFMS_ZERO32;
		if (reg_addr_in == `PFMS_ADDR_CTRL) begin
			rdata_next = {15'h0000, ctrl_reg};
		end else if (reg_addr_in == `PFMS_ADDR_FLAG_DIR) begin
			rdata_next = {24'h000000, flag_dir_reg};
		end else if (reg_addr_in == `PFMS_ADDR_FLAG_OUT) begin
			rdata_next = {24'h000000, flag_val_reg};
		end else if (reg_addr_in == `PFMS_ADDR_FLAG_IN) begin
			rdata_next = {24'h000000, flag_s};
		end else if (reg_addr_in == `PFMS_ADDR_STATUS) begin
			rdata_next = {22'h000000, bus_st_reg, strap_reg, 3'h0, host_mode};
		end else if (reg_addr_in == `PFMS_ADDR_PENDING) begin
			rdata_next = {26'h0000000, req};
		end else if (reg_addr_in == `PFMS_ADDR_HOST_OUT) begin
			rdata_next = {16'h0000, host_out_reg};
		end else if (reg_addr_in == `PFMS_ADDR_EXT) begin
			rdata_next = {8'h00, ext_reg};
		end else if (reg_addr_in == `PFMS_ADDR_HOST_IN) begin
			rdata_next = {8'h00, data_s};
		end
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= `PFMS_ZERO32;
		end else begin
			reg_rdata_out <= reg_rd_in ? rdata_next : `PFMS_ZERO32;
		end
	end
	// Checks.
	a_mode_stable: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!strap_take_reg |=> $stable(strap_reg)) else $error("strap changed");
	a_full_addr: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!host_mode |=> ext_addr_out == $past(ext_reg[13:0])) else $error("addr");
	a_ack_idle_full: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!host_mode ##1 !host_mode |-> !host_ack_n_oe_out) else $error("ack");
	a_irq_masked: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		interrupt_mask_in == 6'h00 |=> irq_vector_req_out == 6'h00) else $error("irq");
	a_grant_state: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		bus_st_reg == pfms_pkg::PFMS_BUS_GRANTED |=> !bus_grant_n_out) else $error("grant");
	a_pwd_ack: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ctl_s[0] |=> !powerdown_ack_out) else $error("pwd");
	a_fixed_flags: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		##1 fixed_output_flags_out == $past(ctrl_reg[`PFMS_CTRL_FIXED_MSB:`PFMS_CTRL_FIXED_LSB]))
		else $error("flags");
	a_alt_rx_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		serial_alt |=> !serial_b_rx_data_out) else $error("alt");
endmodule : pfms_pin_select
`default_nettype wire

// file: pfms_host_model.sv
// Purpose: Far-side model: host port strobes, flag pin wiring, peripheral decode.
// Assumes: Flag pins carry pull-ups; the host makes no access in this run.
// Notes: A flag wire shows the driving party, else the pull-up level.
`timescale 1ns/1ps
`default_nettype none
module pfms_host_model (
	// Clock
	input wire logic ref_clk_in,
	// Flag pin parties
	input wire logic [7:0] ext_val_in,
	input wire logic [7:0] ext_drv_in,
	input wire logic [7:0] flag_out_in,
	input wire logic [7:0] flag_oe_in,
	output logic [7:0] flag_pin_out,
	// Host port strobes
	output logic host_write_n_out,
	output logic host_read_n_out,
	output logic host_addr_latch_out,
	output logic host_select_n_out,
	// Peripheral decode
	input wire logic [13:0] ext_addr_in,
	input wire logic io_sel_n_in,
	output logic periph_hit_out
);
	// The device wins where it drives; an undriven pin rests high.
	assign flag_pin_out = (flag_oe_in & flag_out_in) | (~flag_oe_in & ext_drv_in & ext_val_in)
		| (~flag_oe_in & ~ext_drv_in);
	// Strobes held at their inactive levels.
	assign host_write_n_out = 1'b1;
	assign host_read_n_out = 1'b1;
	assign host_addr_latch_out = 1'b0;
	assign host_select_n_out = 1'b1;
	// One peripheral sits at odd I/O addresses.
	assign periph_hit_out = ~io_sel_n_in & ext_addr_in[0];
endmodule : pfms_host_model
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the pin-function and mode-select block.
// Assumes: Register port reads answer one cycle after the strobe.
// Notes: Table rows first, then hand-written mode, flag and bus cases.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {logic wr; logic [3:0] addr; logic [31:0] data; logic [31:0] exp;} pfms_row_s;
	logic ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in;
	logic [3:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, rd_data;
	logic [5:0] interrupt_mask_in, irq_vector_req_out;
	logic [7:0] prog_flag_in, prog_flag_out, prog_flag_oe_out, ext_val, ext_drv;
	logic [2:0] fixed_output_flags_out;
	logic serial_b_rx_in, serial_b_rfs_in, serial_b_tfs_in, serial_b_tx_data_in;
	logic serial_b_sclk_int_in, serial_b_rx_data_out, serial_b_tx_out, serial_b_sclk_out;
	logic [13:0] ext_addr_out;
	logic [23:0] ext_data_io_in, ext_data_io_out, ext_data_io_oe_out;
	logic host_write_n_in, host_read_n_in, host_addr_latch_in, host_select_n_in;
	logic host_ack_n_out, host_ack_n_oe_out, data_mem_sel_n_out, prog_mem_sel_n_out;
	logic io_space_sel_n_out, byte_mem_sel_n_out, combined_sel_n_out, mem_read_n_out;
	logic mem_write_n_out, bus_req_n_in, bus_grant_n_out, bus_grant_hung_n_out;
	logic powerdown_req_n_in, powerdown_ack_out, host_mode_out, periph_hit;
	logic [8:0] obs;
	int err_count, checked;
	pfms_row_s rows [7];
	assign obs = {powerdown_ack_out, bus_grant_hung_n_out, bus_grant_n_out, irq_vector_req_out};
	pfms_pin_select uut (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .interrupt_mask_in, .irq_vector_req_out, .prog_flag_in,
		.prog_flag_out, .prog_flag_oe_out, .fixed_output_flags_out, .serial_b_rx_in,
		.serial_b_rfs_in, .serial_b_tfs_in, .serial_b_tx_data_in, .serial_b_sclk_int_in,
		.serial_b_rx_data_out, .serial_b_tx_out, .serial_b_sclk_out, .ext_addr_out,
		.ext_data_io_in, .ext_data_io_out, .ext_data_io_oe_out, .host_write_n_in,
		.host_read_n_in, .host_addr_latch_in, .host_select_n_in, .host_ack_n_out,
		.host_ack_n_oe_out, .data_mem_sel_n_out, .prog_mem_sel_n_out, .io_space_sel_n_out,
		.byte_mem_sel_n_out, .combined_sel_n_out, .mem_read_n_out, .mem_write_n_out,
		.bus_req_n_in, .bus_grant_n_out, .bus_grant_hung_n_out, .powerdown_req_n_in,
		.powerdown_ack_out, .host_mode_out);
	pfms_host_model far (.ref_clk_in, .ext_val_in(ext_val), .ext_drv_in(ext_drv),
		.flag_out_in(prog_flag_out), .flag_oe_in(prog_flag_oe_out), .flag_pin_out(prog_flag_in),
		.host_write_n_out(host_write_n_in), .host_read_n_out(host_read_n_in),
		.host_addr_latch_out(host_addr_latch_in), .host_select_n_out(host_select_n_in),
		.ext_addr_in(ext_addr_out), .io_sel_n_in(io_space_sel_n_out), .periph_hit_out(periph_hit));
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 rd_data = reg_rdata_out;
	endtask : rd
	task automatic wait_obs(input int idx, input logic val, input int lim);
		int n;
		n = 0;
		while (obs[idx] !== val && n < lim) begin
			@(posedge ref_clk_in);
			n++;
		end
		chk(obs[idx], val);
		if (obs[idx] !== val) final_report();
	endtask : wait_obs
	task automatic do_reset(input logic [3:0] strap);
		rst_n_in <= 1'b0;
		ext_drv <= 8'h0F;
		ext_val <= {4'hF, strap};
		repeat (6) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		ext_drv <= 8'h00;
		repeat (3) @(posedge ref_clk_in);
	endtask : do_reset
	initial begin
		{rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
		{serial_b_rx_in, serial_b_rfs_in, serial_b_tfs_in, serial_b_tx_data_in} = 4'h0;
		{interrupt_mask_in, ext_data_io_in, ext_val, ext_drv} = '0;
		{serial_b_sclk_int_in, bus_req_n_in, powerdown_req_n_in} = 3'h7;
		err_count = 0;
		checked = 0;
		rows = '{'{1'b0, 4'h0, 32'h0, 32'h0001_F800}, '{1'b0, 4'h9, 32'h0, 32'h0},
			'{1'b0, 4'hF, 32'h0, 32'h0}, '{1'b1, 4'h0, 32'h0001_F805, 32'h0001_F805},
			'{1'b1, 4'h1, 32'h0F, 32'h0F}, '{1'b1, 4'h2, 32'hA5, 32'hA5},
			'{1'b1, 4'h9, 32'hFFFF, 32'h0}};
		do_reset(4'h0);
		chk(host_mode_out, 1'b0);
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].addr, rows[i].data);
			rd(rows[i].addr);
			chk(rd_data, rows[i].exp);
		end
		$display("test table done");
		chk(prog_flag_oe_out, 8'h0F);
		chk(prog_flag_out[3:0], 4'h5);
		wr(4'h0, 32'h0001_FD05);
		chk(fixed_output_flags_out, 3'h5);
		chk(serial_b_tx_out, 1'b1);
		wr(4'h0, 32'h0001_FD04);
		chk(serial_b_tx_out, 1'b0);
		wr(4'h0, 32'h0001_FD09);
		chk(serial_b_sclk_out, 1'b1);
		$display("test serial done");
		interrupt_mask_in <= 6'h3C;
		wr(4'h1, 32'h1F);
		wr(4'h2, 32'h00);
		wait_obs(2, 1'b1, 20);
		ext_drv <= 8'h20;
		ext_val <= 8'h00;
		wait_obs(3, 1'b1, 20);
		ext_drv <= 8'h00;
		wait_obs(3, 1'b0, 20);
		interrupt_mask_in <= 6'h00;
		wait_obs(2, 1'b0, 20);
		$display("test irq done");
		wr(4'h0, 32'h0001_F810);
		bus_req_n_in <= 1'b0;
		wait_obs(6, 1'b0, 20);
		bus_req_n_in <= 1'b1;
		wait_obs(6, 1'b1, 20);
		wr(4'h0, 32'h0001_F800);
		bus_req_n_in <= 1'b0;
		wait_obs(7, 1'b0, 300);
		bus_req_n_in <= 1'b1;
		powerdown_req_n_in <= 1'b0;
		wait_obs(8, 1'b1, 20);
		powerdown_req_n_in <= 1'b1;
		$display("test bus done");
		wr(4'h7, 32'h0000_1235);
		wr(4'h0, 32'h0001_D860);
		chk(ext_addr_out, 14'h1235);
		chk(ext_data_io_oe_out, 24'hFFFFFF);
		chk({mem_read_n_out, mem_write_n_out, io_space_sel_n_out}, 3'h0);
		chk(periph_hit, 1'b1);
		$display("test memory done");
		do_reset(4'h4);
		chk(host_mode_out, 1'b1);
		chk(host_ack_n_out, 1'b0);
		chk(host_ack_n_oe_out, 1'b0);
		wr(4'h6, 32'h0000_0003);
		chk(ext_addr_out, 14'h0006);
		ext_drv <= 8'h0F;
		ext_val <= 8'h00;
		repeat (5) @(posedge ref_clk_in);
		chk(host_mode_out, 1'b1);
		do_reset(4'hB);
		chk(host_mode_out, 1'b0);
		$display("test mode done");
		final_report();
	end
endmodule : tb
`default_nettype wire
